// ### common/nmi_vec_pkg.sv
// constants and types of the nmi entry, return and vectoring unit
package nmi_vec_pkg;

	// ---------------------------------------------------------------
	// register map, byte offsets of aligned 32-bit words
	// ---------------------------------------------------------------
	localparam logic [7:0] OFF_EDGE_MODE   = 8'h00;
	localparam logic [7:0] OFF_STATUS      = 8'h04;
	localparam logic [7:0] OFF_NMI_PC      = 8'h08;
	localparam logic [7:0] OFF_NMI_STATUS  = 8'h0c;
	localparam logic [7:0] OFF_MASK_PC     = 8'h10;
	localparam logic [7:0] OFF_MASK_STATUS = 8'h14;
	localparam logic [7:0] OFF_DEBUG_PC    = 8'h18;
	localparam logic [7:0] OFF_CAUSE       = 8'h1c;

	// ---------------------------------------------------------------
	// field positions
	// ---------------------------------------------------------------
	localparam int EDGE_SEL_BIT   = 0;
	localparam int MASK_BLOCK_BIT = 5;
	localparam int TRAP_BIT       = 6;
	localparam int NMI_BIT        = 7;

	// ---------------------------------------------------------------
	// values after reset
	// ---------------------------------------------------------------
	localparam logic [31:0] STATUS_RESET = 32'h0000_0020;
	localparam logic [31:0] WORD_RESET   = 32'h0000_0000;
	localparam logic        EDGE_RESET   = 1'b0;

	// ---------------------------------------------------------------
	// codes and handler addresses
	// ---------------------------------------------------------------
	localparam logic [15:0] NMI_CODE      = 16'h0010;
	localparam logic [31:0] NMI_HANDLER   = 32'h0000_0010;
	localparam logic [15:0] ILLEGAL_CODE  = 16'h0060;
	localparam logic [31:0] ILLEGAL_HANDLER = 32'h0000_0060;
	localparam logic [15:0] MASK_BASE_CODE = 16'h0260;
	localparam logic [15:0] MASK_CODE_STEP = 16'h0010;
	localparam logic [31:0] ILLEGAL_PC_OFFSET = 32'h0000_0004;
	localparam int          MASK_FIRST_RANK = 30;
	localparam int          MASK_SOURCES    = 22;
	localparam int          DMA_FIRST_INDEX = 3;
	localparam int          DMA_CHANNELS    = 4;
	localparam int          PERIPH_SOURCES  = 18;

	// ---------------------------------------------------------------
	// kind of the instruction in progress at an accept point
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		ABORT_NONE     = 2'b00,
		ABORT_LOAD     = 2'b01,
		ABORT_DIVIDE   = 2'b10,
		ABORT_STACKFRM = 2'b11
	} abort_kind_t;

endpackage

// ### logic/nmi_entry_return_vectoring.sv
// nmi entry, return and maskable vectoring unit with ahb-lite registers
//
// Decided for this implementation: the register addresses and the AHB-Lite interface to the registers.
module nmi_entry_return_vectoring (
	input  wire logic                                 sys_clk,
	input  wire logic                                 rst_b,
	input  wire logic                                 clk_en,
	// ahb-lite slave
	input  wire logic                                 hsel,
	input  wire logic [31:0]                          haddr,
	input  wire logic [1:0]                           htrans,
	input  wire logic                                 hwrite,
	input  wire logic [2:0]                           hsize,
	input  wire logic [31:0]                          hwdata,
	input  wire logic                                 hready,
	output logic      [31:0]                          hrdata,
	output logic                                      hreadyout,
	output logic                                      hresp,
	// pin
	input  wire logic                                 nmi_pin,
	// core pipeline
	input  wire logic                                 accept_point,
	input  wire logic [31:0]                          following_pc,
	input  wire logic [31:0]                          insn_pc,
	input  wire nmi_vec_pkg::abort_kind_t             abort_kind,
	input  wire logic                                 sp_updated,
	input  wire logic                                 illegal_opcode,
	input  wire logic                                 return_req,
	output logic                                      pc_load,
	output logic      [31:0]                          pc_target,
	output logic      [31:0]                          status_word,
	output logic                                      nmi_taken,
	// maskable sources
	input  wire logic [nmi_vec_pkg::PERIPH_SOURCES-1:0] periph_req,
	input  wire logic [nmi_vec_pkg::DMA_CHANNELS-1:0] dma_end_req,
	output logic                                      irq_ack,
	output logic      [5:0]                           irq_ack_rank
);
	import nmi_vec_pkg::*;

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	typedef struct packed {
		logic        pin_meta;
		logic        pin_sync;
		logic        pin_prev;
		logic        nmi_pend;
		logic        edge_sel;
		logic [31:0] status;
		logic [31:0] nmi_pc;
		logic [31:0] nmi_st;
		logic [31:0] mask_pc;
		logic [31:0] mask_st;
		logic [31:0] debug_pc;
		logic [31:0] cause;
		logic        ph_valid;
		logic        ph_write;
		logic [7:0]  ph_addr;
		logic [31:0] rdata;
		logic        pc_load;
		logic [31:0] pc_target;
		logic        nmi_taken;
		logic        irq_ack;
		logic [5:0]  ack_rank;
	} state_t;

	state_t st;
	state_t next_st;

	// ---------------------------------------------------------------
	// combinational helpers
	// ---------------------------------------------------------------
	logic [MASK_SOURCES-1:0] mask_req;
	logic                    mask_any;
	logic [4:0]              mask_idx;
	logic                    nmi_edge;
	logic [31:0]             save_pc;
	logic [31:0]             rd_mux;
	logic                    np;
	logic                    ep;
	logic                    id;

	// dma channels sit in channel order at ranks 33..36
	assign mask_req = {periph_req[PERIPH_SOURCES-1:DMA_FIRST_INDEX],
	                   dma_end_req,
	                   periph_req[DMA_FIRST_INDEX-1:0]};

	// lowest index is the highest default priority
	always_comb begin
		mask_any = 1'b0;
		mask_idx = 5'h00;
		for (int i = MASK_SOURCES - 1; i >= 0; i--) begin
			if (mask_req[i]) begin
				mask_any = 1'b1;
				mask_idx = 5'(i);
			end
		end
	end

	assign np = st.status[NMI_BIT];
	assign ep = st.status[TRAP_BIT];
	assign id = st.status[MASK_BLOCK_BIT];

	// edge on the second synchroniser stage against its delayed copy
	assign nmi_edge = st.edge_sel ? (st.pin_sync & ~st.pin_prev)
	                              : (~st.pin_sync & st.pin_prev);

	// return address of an asynchronous event at this accept point
	always_comb begin
		save_pc = following_pc;
		if (abort_kind == ABORT_LOAD || abort_kind == ABORT_DIVIDE) begin
			save_pc = insn_pc;
		end else if (abort_kind == ABORT_STACKFRM && !sp_updated) begin
			save_pc = insn_pc;
		end
	end

	// register read mux
	always_comb begin
		rd_mux = WORD_RESET;
		if (st.ph_addr == OFF_EDGE_MODE) begin
			rd_mux[EDGE_SEL_BIT] = st.edge_sel;
		end else if (st.ph_addr == OFF_STATUS) begin
			rd_mux = st.status;
		end else if (st.ph_addr == OFF_NMI_PC) begin
			rd_mux = st.nmi_pc;
		end else if (st.ph_addr == OFF_NMI_STATUS) begin
			rd_mux = st.nmi_st;
		end else if (st.ph_addr == OFF_MASK_PC) begin
			rd_mux = st.mask_pc;
		end else if (st.ph_addr == OFF_MASK_STATUS) begin
			rd_mux = st.mask_st;
		end else if (st.ph_addr == OFF_DEBUG_PC) begin
			rd_mux = st.debug_pc;
		end else if (st.ph_addr == OFF_CAUSE) begin
			rd_mux = st.cause;
		end
	end

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb begin
		next_st = st;
		next_st.pc_load   = 1'b0;
		next_st.nmi_taken = 1'b0;
		next_st.irq_ack   = 1'b0;

		// synchroniser, first stage feeds only the second
		next_st.pin_meta = nmi_pin;
		next_st.pin_sync = st.pin_meta;
		next_st.pin_prev = st.pin_sync;

		// bus: register writes in the data phase
		if (st.ph_valid && st.ph_write) begin
			if (st.ph_addr == OFF_EDGE_MODE) begin
				next_st.edge_sel = hwdata[EDGE_SEL_BIT];
			end else if (st.ph_addr == OFF_STATUS) begin
				next_st.status = hwdata;
			end else if (st.ph_addr == OFF_NMI_PC) begin
				next_st.nmi_pc = hwdata;
			end else if (st.ph_addr == OFF_NMI_STATUS) begin
				next_st.nmi_st = hwdata;
			end else if (st.ph_addr == OFF_MASK_PC) begin
				next_st.mask_pc = hwdata;
			end else if (st.ph_addr == OFF_MASK_STATUS) begin
				next_st.mask_st = hwdata;
			end else if (st.ph_addr == OFF_DEBUG_PC) begin
				next_st.debug_pc = hwdata;
			end else if (st.ph_addr == OFF_CAUSE) begin
				next_st.cause = hwdata;
			end
		end

		// bus: the first read data cycle waits while the word is registered
		if (st.ph_valid && !st.ph_write) begin
			next_st.rdata = rd_mux;
		end
		next_st.ph_valid = 1'b0;
		if (hsel && htrans[1] && hready) begin
			next_st.ph_valid = 1'b1;
			next_st.ph_write = hwrite;
			next_st.ph_addr  = {haddr[7:2], 2'b00};
		end

		// hardware events override a software write of the same cycle
		if (return_req) begin
			next_st.pc_load = 1'b1;
			if (!ep && np) begin
				next_st.pc_target = st.nmi_pc;
				next_st.status    = st.nmi_st;
			end else if (!ep && !np) begin
				next_st.pc_target = st.mask_pc;
				next_st.status    = st.mask_st;
			end else begin
				next_st.pc_target = st.debug_pc;
				next_st.status    = st.mask_st;
			end
		end else if (accept_point && !np) begin
			if (st.nmi_pend) begin
				// no mask or block bit is looked at here
				next_st.nmi_pend = 1'b0;
				next_st.nmi_pc   = save_pc;
				next_st.nmi_st   = st.status;
				next_st.cause[31:16] = NMI_CODE;
				next_st.status[NMI_BIT]        = 1'b1;
				next_st.status[MASK_BLOCK_BIT] = 1'b1;
				next_st.status[TRAP_BIT]       = 1'b0;
				next_st.pc_target = NMI_HANDLER;
				next_st.pc_load   = 1'b1;
				next_st.nmi_taken = 1'b1;
			end else if (illegal_opcode) begin
				next_st.debug_pc = following_pc + ILLEGAL_PC_OFFSET;
				next_st.cause[15:0] = ILLEGAL_CODE;
				next_st.status[MASK_BLOCK_BIT] = 1'b1;
				next_st.status[TRAP_BIT]       = 1'b1;
				next_st.pc_target = ILLEGAL_HANDLER;
				next_st.pc_load   = 1'b1;
			end else if (mask_any && !id) begin
				next_st.mask_pc = save_pc;
				next_st.mask_st = st.status;
				next_st.cause[15:0] = MASK_BASE_CODE
				                    + 16'(mask_idx) * MASK_CODE_STEP;
				next_st.status[MASK_BLOCK_BIT] = 1'b1;
				next_st.status[TRAP_BIT]       = 1'b0;
				next_st.pc_target = {16'h0000, MASK_BASE_CODE
				                    + 16'(mask_idx) * MASK_CODE_STEP};
				next_st.pc_load  = 1'b1;
				next_st.irq_ack  = 1'b1;
				next_st.ack_rank = 6'(mask_idx) + 6'(MASK_FIRST_RANK);
			end
		end

		// a new edge always sets the single pending flag, winning over clear
		if (nmi_edge) begin
			next_st.nmi_pend = 1'b1;
		end
	end

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			st <= '0;
			st.status   <= STATUS_RESET;
			st.edge_sel <= EDGE_RESET;
		end else if (clk_en) begin
			st <= next_st;
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign hrdata       = st.rdata;
	assign hreadyout    = ~(st.ph_valid & ~st.ph_write);
	assign hresp        = 1'b0;
	assign pc_load      = st.pc_load;
	assign pc_target    = st.pc_target;
	assign status_word  = st.status;
	assign nmi_taken    = st.nmi_taken;
	assign irq_ack      = st.irq_ack;
	assign irq_ack_rank = st.ack_rank;

endmodule

// ### sim/core_model.sv
// core pipeline partner: instruction boundaries and program counter
module core_model (
	input  wire logic        sys_clk,
	input  wire logic        rst_b,
	input  wire logic        slow,
	input  wire logic        stall,
	input  wire logic        pc_load,
	input  wire logic [31:0] pc_target,
	output logic             accept_point,
	output logic [31:0]      following_pc,
	output logic [31:0]      insn_pc
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] pc;
	logic        go;

	// ---------------------------------------------------------------
	// program counter, redirected by every jump
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			pc <= 32'h0000_0100;
			go <= 1'b1;
		end else begin
			if (pc_load)
				pc <= pc_target;
			go <= !slow || $urandom_range(1);
		end
	end

	// no boundary while a new target is fetched
	assign accept_point = go && !stall && !pc_load;
	assign insn_pc      = pc;
	assign following_pc = pc + 32'h4;
	// handler code never rewrites the trap or nmi bits
endmodule

// ### sim/nmi_entry_return_vectoring_chk.sv
// port assertions of the nmi entry, return and vectoring unit
module nmi_entry_return_vectoring_chk (
	input wire logic        sys_clk,
	input wire logic        rst_b,
	input wire logic        hsel,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic        accept_point,
	input wire logic        return_req,
	input wire logic        pc_load,
	input wire logic [31:0] pc_target,
	input wire logic [31:0] status_word,
	input wire logic        nmi_taken,
	input wire logic        irq_ack,
	input wire logic [5:0]  irq_ack_rank
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_b);

	sequence rd_taken;
		hsel && htrans[1] && hready && !hwrite;
	endsequence
	sequence rd_answer;
		!hreadyout ##1 hreadyout;
	endsequence

	AST_READ_WAIT:
		assert property (rd_taken |=> rd_answer)
		else $error("read wait state wrong");
	AST_NMI_JUMP:
		assert property (nmi_taken |-> pc_load && pc_target == 32'h10)
		else $error("nmi jump wrong");
	AST_NMI_BITS:
		assert property (nmi_taken |-> status_word[7:5] == 3'b101)
		else $error("nmi status bits wrong");
	AST_NO_NEST:
		assert property (status_word[7] |=> !irq_ack && !nmi_taken)
		else $error("event taken inside nmi handler");
	AST_ONE_WIN:
		assert property (!(irq_ack && nmi_taken))
		else $error("nmi and maskable taken together");
	AST_VECTOR:
		assert property (irq_ack |-> pc_load && irq_ack_rank inside {[30:51]}
			&& pc_target == {22'h0, irq_ack_rank, 4'h0} + 32'h80)
		else $error("maskable vector wrong");
	AST_RET_LOAD:
		assert property (return_req |=> pc_load && !irq_ack && !nmi_taken)
		else $error("return gave no jump");
	AST_BOUNDARY:
		assert property (nmi_taken |-> $past(accept_point)
			&& !$past(status_word[7]))
		else $error("nmi taken off a boundary");
endmodule

bind nmi_entry_return_vectoring nmi_entry_return_vectoring_chk chk_i (
	.sys_clk, .rst_b, .hsel, .htrans, .hwrite, .hready, .hreadyout,
	.accept_point, .return_req, .pc_load, .pc_target, .status_word,
	.nmi_taken, .irq_ack, .irq_ack_rank);

// ### sim/nmi_entry_return_vectoring_tb_top.sv
// self-checking testbench of the nmi entry, return and vectoring unit
module nmi_entry_return_vectoring_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import nmi_vec_pkg::*;
	logic        sys_clk, rst_b, clk_en, hsel, hwrite, hready, hreadyout;
	logic        hresp, nmi_pin, accept_point, sp_updated, illegal_opcode;
	logic        return_req, pc_load, nmi_taken, irq_ack, slow, stall;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [5:0]  irq_ack_rank;
	logic [21:0] r;
	logic [31:0] haddr, hwdata, hrdata, following_pc, insn_pc, pc_target;
	logic [31:0] status_word, s, pc_q[$], rd_q[$];
	logic        rd_on;
	int          bad_count, compares;
	abort_kind_t abort_kind;
	logic [PERIPH_SOURCES-1:0] periph_req;
	logic [DMA_CHANNELS-1:0]   dma_end_req;

	nmi_entry_return_vectoring nmi_entry_return_vectoring_i (.*);
	core_model core_model_i (.sys_clk(sys_clk), .rst_b(rst_b), .slow(slow),
		.stall(stall), .pc_load(pc_load), .pc_target(pc_target),
		.accept_point(accept_point), .following_pc(following_pc),
		.insn_pc(insn_pc));
	assign hready = hreadyout;

	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end

	// ---------------------------------------------------------------
	// checking and bus tasks
	// ---------------------------------------------------------------
	task automatic err(input string m);
		bad_count++;
		$display("[FAIL] %0t %s", $time, m);
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e)
			err($sformatf("got %h want %h", g, e));
	endtask
	task automatic wrap_up;
		if (bad_count == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int m;
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= {24'h0, a};
		for (int n = 0; n < 2; n++) begin
			m = 0;
			do begin
				@(posedge sys_clk);
				m++;
			end while (!hready && m < 50);
			if (m >= 50) begin
				err("bus hang");
				wrap_up;
			end
			if (n == 0) begin
				hsel <= 1'b0;
				htrans <= 2'b00;
				hwdata <= d;
			end
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		rd_q.push_back(e);
		bus(1'b0, a, 32'h0);
	endtask
	task automatic settle;
		for (int n = 0; n < 200 && pc_q.size() != 0; n++)
			@(posedge sys_clk);
		repeat (4) @(posedge sys_clk);
		if (pc_q.size() != 0) begin
			err("timeout");
			wrap_up;
		end
	endtask
	task automatic pin(input logic v);
		nmi_pin <= v;
		repeat (4) @(posedge sys_clk);
	endtask
	task automatic ret;
		return_req <= 1'b1;
		@(posedge sys_clk);
		return_req <= 1'b0;
	endtask
	task automatic nmi_cycle(input logic [31:0] v);
		pc_q.push_back(NMI_HANDLER);
		pin(1'b0);
		pin(1'b1);
		settle;
		rd(OFF_NMI_PC, v);
		pc_q.push_back(v);
		ret;
		settle;
	endtask

	// results are compared in order as they appear
	always @(posedge sys_clk) begin
		if (rd_on && hready) begin
			rd_on = 1'b0;
			chk(hrdata, rd_q.pop_front());
		end
		if (hsel && htrans[1] && hready && !hwrite)
			rd_on = 1'b1;
		if (pc_load && pc_q.size() == 0)
			err("unexpected jump");
		else if (pc_load)
			chk(pc_target, pc_q.pop_front());
	end

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		{rst_b, hsel, hwrite, return_req, illegal_opcode, rd_on} = '0;
		{sp_updated, slow, stall, htrans, haddr, hwdata} = '0;
		{periph_req, dma_end_req, bad_count, compares} = '0;
		abort_kind = ABORT_NONE;
		hsize = 3'b010;
		nmi_pin = 1'b1;
		clk_en = 1'b1;
		void'($urandom(32'h70346d57));
		repeat (16) @(posedge sys_clk);
		rst_b <= 1'b1;
		rd(OFF_STATUS, STATUS_RESET);
		rd(OFF_EDGE_MODE, WORD_RESET);
		rd(8'h20, WORD_RESET);
		pc_q.push_back(NMI_HANDLER);
		pin(1'b0);
		pin(1'b1);
		pin(1'b0);
		pin(1'b1);
		pin(1'b0);
		settle;
		rd(OFF_STATUS, STATUS_RESET | 32'h80);
		rd(OFF_NMI_PC, 32'h104);
		rd(OFF_NMI_STATUS, STATUS_RESET);
		rd(OFF_CAUSE, {NMI_CODE, 16'h0});
		pc_q.push_back(32'h104);
		pc_q.push_back(NMI_HANDLER);
		ret;
		settle;
		rd(OFF_NMI_PC, 32'h108);
		pc_q.push_back(32'h108);
		ret;
		settle;
		bus(1'b1, OFF_EDGE_MODE, 32'h1);
		for (int k = 0; k < 5; k++) begin
			abort_kind <= abort_kind_t'(k == 4 ? 3 : k);
			sp_updated <= (k == 4);
			@(posedge sys_clk);
			s = (k > 0 && k < 4) ? insn_pc : following_pc;
			nmi_cycle(s);
		end
		abort_kind <= ABORT_NONE;
		s = following_pc + ILLEGAL_PC_OFFSET;
		pc_q.push_back(ILLEGAL_HANDLER);
		illegal_opcode <= 1'b1;
		@(posedge sys_clk);
		illegal_opcode <= 1'b0;
		settle;
		rd(OFF_DEBUG_PC, s);
		pc_q.push_back(s);
		ret;
		settle;
		slow <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			bus(1'b1, OFF_STATUS, WORD_RESET);
			r = (i == 0) ? 22'h000078 : 22'($urandom) | 22'h200000;
			periph_req <= {r[21:7], r[2:0]};
			dma_end_req <= r[6:3];
			for (int j = 21; j >= 0; j--)
				if (r[j])
					s = 32'h260 + 32'(j) * 32'h10;
			pc_q.push_back(s);
			settle;
			{periph_req, dma_end_req} <= '0;
		end
		slow <= 1'b0;
		stall <= 1'b1;
		bus(1'b1, OFF_STATUS, WORD_RESET);
		periph_req <= '1;
		pin(1'b0);
		pin(1'b1);
		s = following_pc;
		pc_q.push_back(NMI_HANDLER);
		stall <= 1'b0;
		settle;
		pc_q.push_back(s);
		pc_q.push_back(32'h260);
		ret;
		settle;
		pc_q.push_back(s + 32'h4);
		periph_req <= '0;
		ret;
		settle;
		wrap_up;
	end
endmodule
